// ==== rtl/tmr8_core.sv ====
// 8-bit timer with normal, clear-on-match, fast and phase-correct pwm waveform modes
// How it works
// - clear-on-match sets compare_a_flag at TOP match
// - no buffering in clear-on-match; missed matches wrap
// - toggle action inverts wave_out_a every match
// - clear-on-match overflow flag on MAX to zero
// - tick prescale is 1, 8, 64, 256, 1024
// - fast pwm: modes 3/7, TOP 0xFF or compare_a
// - fast action 2 clear-match/set-bottom; 3 inverted
// - fast counter clears tick after TOP; bottom action
// - fast pwm overflow flag set at TOP
// - channel A toggle in pwm only with msb
// - fast period is prescale times 256 clocks in mode 3; mode 7 is prescale times compare_a plus one
// - fast extremes: bottom spike, MAX constant level
// - fast pwm compare writes go through buffer
// - phase pwm: modes 1/5, up then down
// - phase: up match clears, down match sets
// - phase counter holds TOP one tick, reverses
// - phase pwm overflow flag set at BOTTOM
// - phase period is prescale times 510 clocks in mode 1; mode 5 is prescale times twice compare_a
// - phase extremes: bottom low, MAX high
// - phase: missed up transition applied at the TOP turn
// - fully synchronous; tick only enables counting
// - mode 2 clears counter on compare_a match
// - action zero leaves wave register unchanged
`timescale 1ns/1ps
`include "tmr8_map.svh"

module tmr8_core
  import tmr8_pkg::*;
#(
  parameter int unsigned DIV_W = 10
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic [2:0] clock_select_i,
  input  wire logic [2:0] waveform_select_i,
  input  wire logic [1:0] output_action_a_i,
  input  wire logic [1:0] output_action_b_i,
  input  wire logic [7:0] compare_a_value_i,
  input  wire logic [7:0] compare_b_value_i,
  input  wire logic       counter_write_i,
  input  wire logic [7:0] counter_write_data_i,
  input  wire logic       compare_a_flag_clear_i,
  input  wire logic       compare_b_flag_clear_i,
  input  wire logic       overflow_flag_clear_i,
  output logic [7:0]      counter_value_o,
  output logic            counting_down_o,
  output logic            wave_out_a_o,
  output logic            wave_out_b_o,
  output logic            compare_a_flag_o,
  output logic            compare_b_flag_o,
  output logic            overflow_flag_o
);

  function automatic tmr8_mode_t tmr8_decode_mode(input logic [2:0] ws);
    case (ws)
      `TMR8_WS_PHASE_FF, `TMR8_WS_PHASE_OCR: tmr8_decode_mode = TMR8_MODE_PHASE;
      `TMR8_WS_CTC:                          tmr8_decode_mode = TMR8_MODE_CTC;
      `TMR8_WS_FAST_FF, `TMR8_WS_FAST_OCR:   tmr8_decode_mode = TMR8_MODE_FAST;
      default:                               tmr8_decode_mode = TMR8_MODE_NORMAL;
    endcase
  endfunction

  logic        timer_tick;
  tmr8_mode_t  mode;
  logic        pwm;
  tmr8_count_t cmp_in [2];
  logic [1:0]  act    [2];
  tmr8_count_t cmp_eff[2];
  tmr8_count_t top;
  tmr8_count_t new_top;
  logic        at_top;
  logic        at_bot;
  logic        turn_top;
  logic        fast_wrap;
  logic        buf_load;
  logic [1:0]  match;

  tmr8_count_t cnt_reg;
  tmr8_count_t cnt_next;
  logic        down_reg;
  logic        down_next;
  logic        ovf_reg;
  logic        ovf_next;
  tmr8_count_t ocr_reg [2];
  tmr8_count_t ocr_next[2];
  logic [1:0]  wave_reg;
  logic [1:0]  wave_next;
  logic [1:0]  upm_reg;
  logic [1:0]  upm_next;
  logic [1:0]  cf_reg;
  logic [1:0]  cf_next;
  logic [1:0]  cf_clear;

  tmr8_prescaler #(
    .DIV_W (DIV_W)
  ) u_prescaler (
    .clk_sys_i      (clk_sys_i),
    .rst_n_i        (rst_n_i),
    .clock_select_i (clock_select_i),
    .timer_tick_o   (timer_tick)
  );

  assign mode      = tmr8_decode_mode(waveform_select_i);
  assign pwm       = (mode == TMR8_MODE_FAST) || (mode == TMR8_MODE_PHASE);
  assign cmp_in[0] = compare_a_value_i;
  assign cmp_in[1] = compare_b_value_i;
  assign act[0]    = output_action_a_i;
  assign act[1]    = output_action_b_i;
  assign cf_clear  = {compare_b_flag_clear_i, compare_a_flag_clear_i};

  // non-pwm modes see the written value at once, pwm modes the buffered copy
  assign cmp_eff[0] = pwm ? ocr_reg[0] : cmp_in[0];
  assign cmp_eff[1] = pwm ? ocr_reg[1] : cmp_in[1];

  always_comb begin
    top = `TMR8_MAX;
    if (mode == TMR8_MODE_CTC || waveform_select_i == `TMR8_WS_FAST_OCR ||
        waveform_select_i == `TMR8_WS_PHASE_OCR) begin
      top = cmp_eff[0];
    end
  end

  // top that follows a buffer load at the turning point
  assign new_top   = (waveform_select_i == `TMR8_WS_PHASE_OCR) ? cmp_in[0] : `TMR8_MAX;
  assign at_top    = (cnt_reg == top);
  assign at_bot    = (cnt_reg == `TMR8_BOTTOM);
  assign turn_top  = timer_tick && (mode == TMR8_MODE_PHASE) && !down_reg && at_top;
  assign fast_wrap = timer_tick && (mode == TMR8_MODE_FAST) && at_top;
  assign buf_load  = fast_wrap || turn_top;

  // a counter write wins over the tick and suppresses that tick's match
  assign match[0] = timer_tick && !counter_write_i && (cnt_reg == cmp_eff[0]);
  assign match[1] = timer_tick && !counter_write_i && (cnt_reg == cmp_eff[1]);

  // counter, direction and overflow
  always_comb begin
    cnt_next  = cnt_reg;
    down_next = down_reg;
    ovf_next  = ovf_reg && !overflow_flag_clear_i;
    if (mode != TMR8_MODE_PHASE) begin
      down_next = 1'b0;
    end
    if (counter_write_i) begin
      cnt_next = counter_write_data_i;
    end else if (timer_tick) begin
      case (mode)
        TMR8_MODE_CTC: begin
          cnt_next = at_top ? `TMR8_BOTTOM : cnt_reg + 8'h01;
          if (cnt_reg == `TMR8_MAX) begin
            ovf_next = 1'b1;
          end
        end
        TMR8_MODE_FAST: begin
          cnt_next = at_top ? `TMR8_BOTTOM : cnt_reg + 8'h01;
          if (at_top) begin
            ovf_next = 1'b1;
          end
        end
        TMR8_MODE_PHASE: begin
          if (!down_reg) begin
            if (at_top) begin
              down_next = 1'b1;
              cnt_next  = at_bot ? `TMR8_BOTTOM : cnt_reg - 8'h01;
            end else begin
              cnt_next = cnt_reg + 8'h01;
            end
          end else if (at_bot) begin
            down_next = 1'b0;
            ovf_next  = 1'b1;
            cnt_next  = at_top ? `TMR8_BOTTOM : cnt_reg + 8'h01;
          end else begin
            cnt_next = cnt_reg - 8'h01;
          end
        end
        default: begin
          cnt_next = cnt_reg + 8'h01;
          if (cnt_reg == `TMR8_MAX) begin
            ovf_next = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg  <= `TMR8_CNT_RESET;
      down_reg <= 1'b0;
      ovf_reg  <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      down_reg <= down_next;
      ovf_reg  <= ovf_next;
    end
  end

  // per channel compare buffer, wave register, up-match memory and flag
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic tgl_ok;
    logic up_lvl;
    logic up_side;

    assign tgl_ok  = (ch == 0) && waveform_select_i[`TMR8_WS_MSB];
    // level an up-count match leaves; inverted action gives the opposite
    assign up_lvl  = (act[ch] == `TMR8_ACT_SET);
    assign up_side = !down_reg || at_bot;

    always_comb begin
      ocr_next[ch]  = ocr_reg[ch];
      wave_next[ch] = wave_reg[ch];
      upm_next[ch]  = upm_reg[ch];
      // set wins over clear so a match in the clearing cycle is kept
      cf_next[ch]   = (cf_reg[ch] && !cf_clear[ch]) || match[ch];
      if (!pwm || buf_load) begin
        ocr_next[ch] = cmp_in[ch];
      end
      case (mode)
        TMR8_MODE_FAST: begin
          if (act[ch] == `TMR8_ACT_TOGGLE) begin
            if (tgl_ok && match[ch]) begin
              wave_next[ch] = !wave_reg[ch];
            end
          end else if (act[ch] != `TMR8_ACT_NONE) begin
            // bottom action first: a match at TOP is ignored
            if (fast_wrap) begin
              wave_next[ch] = (act[ch] == `TMR8_ACT_CLEAR);
            end else if (match[ch]) begin
              wave_next[ch] = (act[ch] == `TMR8_ACT_SET);
            end
          end
        end
        TMR8_MODE_PHASE: begin
          if (turn_top) begin
            upm_next[ch] = 1'b0;
          end else if (match[ch] && up_side) begin
            upm_next[ch] = 1'b1;
          end
          if (act[ch] == `TMR8_ACT_TOGGLE) begin
            if (tgl_ok && match[ch]) begin
              wave_next[ch] = !wave_reg[ch];
            end
          end else if (act[ch] != `TMR8_ACT_NONE) begin
            if (turn_top) begin
              // compare at the new top holds the down level; otherwise a missed up edge lands here
              if (cmp_in[ch] == new_top) begin
                wave_next[ch] = !up_lvl;
              end else if (!upm_reg[ch]) begin
                wave_next[ch] = up_lvl;
              end
            end else if (match[ch]) begin
              wave_next[ch] = up_side ? up_lvl : !up_lvl;
            end
          end
        end
        default: begin
          if (match[ch]) begin
            case (act[ch])
              `TMR8_ACT_TOGGLE: wave_next[ch] = !wave_reg[ch];
              `TMR8_ACT_CLEAR:  wave_next[ch] = 1'b0;
              `TMR8_ACT_SET:    wave_next[ch] = 1'b1;
              default:          wave_next[ch] = wave_reg[ch];
            endcase
          end
        end
      endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        ocr_reg[ch]  <= `TMR8_CMP_RESET;
        wave_reg[ch] <= 1'b0;
        upm_reg[ch]  <= 1'b0;
        cf_reg[ch]   <= 1'b0;
      end else begin
        ocr_reg[ch]  <= ocr_next[ch];
        wave_reg[ch] <= wave_next[ch];
        upm_reg[ch]  <= upm_next[ch];
        cf_reg[ch]   <= cf_next[ch];
      end
    end
  end

  assign counter_value_o  = cnt_reg;
  assign counting_down_o  = down_reg;
  assign wave_out_a_o     = wave_reg[0];
  assign wave_out_b_o     = wave_reg[1];
  assign compare_a_flag_o = cf_reg[0];
  assign compare_b_flag_o = cf_reg[1];
  assign overflow_flag_o  = ovf_reg;

endmodule

// ==== rtl/tmr8_map.svh ====
// offsets of encodings, reset values and prescale constants for the 8-bit waveform timer
`ifndef TMR8_MAP_SVH
`define TMR8_MAP_SVH

`define TMR8_BOTTOM       8'h00
`define TMR8_MAX          8'hFF
`define TMR8_CNT_RESET    8'h00
`define TMR8_CMP_RESET    8'h00

`define TMR8_WS_NORMAL    3'h0
`define TMR8_WS_PHASE_FF  3'h1
`define TMR8_WS_CTC       3'h2
`define TMR8_WS_FAST_FF   3'h3
`define TMR8_WS_PHASE_OCR 3'h5
`define TMR8_WS_FAST_OCR  3'h7
`define TMR8_WS_MSB       2

`define TMR8_ACT_NONE     2'h0
`define TMR8_ACT_TOGGLE   2'h1
`define TMR8_ACT_CLEAR    2'h2
`define TMR8_ACT_SET      2'h3

`define TMR8_CS_STOP      3'h0
`define TMR8_CS_DIV1      3'h1
`define TMR8_CS_DIV8      3'h2
`define TMR8_CS_DIV64     3'h3
`define TMR8_CS_DIV256    3'h4
`define TMR8_CS_DIV1024   3'h5

`define TMR8_DIV1_LAST    10'h000
`define TMR8_DIV8_LAST    10'h007
`define TMR8_DIV64_LAST   10'h03F
`define TMR8_DIV256_LAST  10'h0FF
`define TMR8_DIV1024_LAST 10'h3FF

`endif

// ==== rtl/tmr8_pkg.sv ====
// types shared by the 8-bit waveform timer
package tmr8_pkg;

  // counting style, gray coded along normal -> phase -> ctc -> fast
  typedef enum logic [1:0] {
    TMR8_MODE_NORMAL = 2'h0,
    TMR8_MODE_PHASE  = 2'h1,
    TMR8_MODE_CTC    = 2'h3,
    TMR8_MODE_FAST   = 2'h2
  } tmr8_mode_t;

  typedef logic [7:0] tmr8_count_t;

endpackage

// ==== rtl/tmr8_prescaler.sv ====
// prescaler forming the one-cycle timer tick from the system clock
`timescale 1ns/1ps
`include "tmr8_map.svh"

module tmr8_prescaler
  import tmr8_pkg::*;
#(
  parameter int unsigned DIV_W = 10
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic [2:0] clock_select_i,
  output logic            timer_tick_o
);

  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;
  logic             tick_reg;
  logic             tick_next;
  logic [DIV_W-1:0] div_last;

  always_comb begin
    div_last  = DIV_W'(`TMR8_DIV1_LAST);
    div_next  = div_reg;
    tick_next = 1'b0;
    case (clock_select_i)
      `TMR8_CS_DIV8:    div_last = DIV_W'(`TMR8_DIV8_LAST);
      `TMR8_CS_DIV64:   div_last = DIV_W'(`TMR8_DIV64_LAST);
      `TMR8_CS_DIV256:  div_last = DIV_W'(`TMR8_DIV256_LAST);
      `TMR8_CS_DIV1024: div_last = DIV_W'(`TMR8_DIV1024_LAST);
      default:          div_last = DIV_W'(`TMR8_DIV1_LAST);
    endcase
    if (clock_select_i == `TMR8_CS_STOP || clock_select_i > `TMR8_CS_DIV1024) begin
      div_next = '0;
    end else if (div_reg >= div_last) begin
      div_next  = '0;
      tick_next = 1'b1;
    end else begin
      div_next = div_reg + DIV_W'(1);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= div_next;
      tick_reg <= tick_next;
    end
  end

  assign timer_tick_o = tick_reg;

endmodule

// ==== dv/tmr8_core_assertions.sv ====
// concurrent checks on the waveform timer core ports
`timescale 1ns/1ps
module tmr8_chk
  import tmr8_pkg::*;
(
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  input wire logic [2:0] clock_select_i,
  input wire logic [2:0] waveform_select_i,
  input wire logic [1:0] output_action_a_i,
  input wire logic [1:0] output_action_b_i,
  input wire logic [7:0] compare_a_value_i,
  input wire logic       counter_write_i,
  input wire logic [7:0] counter_value_o,
  input wire logic       counting_down_o,
  input wire logic       wave_out_a_o,
  input wire logic       wave_out_b_o,
  input wire logic       compare_a_flag_o,
  input wire logic       overflow_flag_o
);
  logic [1:0] age_reg;
  logic [1:0] age_next;
  logic       run;
  logic       hit;
  logic       phs;
  logic       fst;
  always_comb begin
    age_next = age_reg;
    if (age_reg != 2'h3) begin
      age_next = age_reg + 2'h1;
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      age_reg <= 2'h0;
    end else begin
      age_reg <= age_next;
    end
  end
  // edges equal ticks only at /1; a counter write drops its own tick
  assign run = age_reg == 2'h3 && clock_select_i == 3'h1 && !counter_write_i;
  assign hit = run && waveform_select_i == 3'h2 && counter_value_o == compare_a_value_i;
  assign phs = run && waveform_select_i == 3'h1;
  assign fst = run && waveform_select_i == 3'h3;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_top;
    phs && counter_value_o == 8'hFE && !counting_down_o ##1 phs && counter_value_o == 8'hFF;
  endsequence
  a_ctc_clear: assert property (hit |=> counter_value_o == 8'h00)
    else $error("counter not cleared on match");
  a_ctc_flag: assert property (hit |=> compare_a_flag_o)
    else $error("compare flag not set on match");
  a_ctc_toggle: assert property (hit && output_action_a_i == 2'h1
    |=> wave_out_a_o != $past(wave_out_a_o))
    else $error("wave did not toggle");
  a_ctc_wrap: assert property (run && waveform_select_i == 3'h2
    && counter_value_o == 8'hFF && compare_a_value_i != 8'hFF
    |=> counter_value_o == 8'h00 && overflow_flag_o)
    else $error("missed match did not wrap");
  a_act_none: assert property (run && waveform_select_i == 3'h2
    && output_action_a_i == 2'h0 |=> $stable(wave_out_a_o))
    else $error("wave moved with no action");
  a_fast_wrap: assert property (fst && counter_value_o == 8'hFF
    |=> counter_value_o == 8'h00 && overflow_flag_o)
    else $error("fast counter did not wrap");
  a_fast_bottom: assert property (fst && counter_value_o == 8'hFF
    && output_action_a_i == 2'h2 |=> wave_out_a_o)
    else $error("bottom did not set wave");
  a_b_no_toggle: assert property (fst && output_action_b_i == 2'h1
    |=> $stable(wave_out_b_o))
    else $error("channel b toggled in pwm");
  a_phase_turn: assert property (s_top |=> counter_value_o == 8'hFE && counting_down_o)
    else $error("no turn at top");
  a_phase_bottom: assert property (phs && counter_value_o == 8'h00 && counting_down_o
    |=> overflow_flag_o && counter_value_o == 8'h01 && !counting_down_o)
    else $error("no overflow at bottom");
endmodule

bind tmr8_core tmr8_chk u_chk (.clk_sys_i, .rst_n_i, .clock_select_i, .waveform_select_i,
  .output_action_a_i, .output_action_b_i, .compare_a_value_i, .counter_write_i, .counter_value_o,
  .counting_down_o, .wave_out_a_o, .wave_out_b_o, .compare_a_flag_o, .overflow_flag_o);

// ==== dv/tmr8_tb.sv ====
// self-checking bench for the waveform timer core
`timescale 1ns/1ps
module tb;
  import tmr8_pkg::*;
  logic       clk_sys_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [2:0] clock_select_i = 3'h1;
  logic [2:0] waveform_select_i = 3'h0;
  logic [1:0] output_action_a_i = 2'h0;
  logic [1:0] output_action_b_i = 2'h0;
  logic [7:0] compare_a_value_i = 8'h00;
  logic [7:0] compare_b_value_i = 8'h01;
  logic       counter_write_i = 1'b0;
  logic [7:0] counter_write_data_i = 8'h00;
  logic       compare_a_flag_clear_i = 1'b0;
  logic       compare_b_flag_clear_i = 1'b0;
  logic       overflow_flag_clear_i = 1'b0;
  logic [7:0] counter_value_o;
  logic       counting_down_o, wave_out_a_o, wave_out_b_o;
  logic       compare_a_flag_o, compare_b_flag_o, overflow_flag_o;
  int         errors = 0;
  int         comparisons = 0;
  int         hi, tog_a, tog_b, top;
  int         dv[5] = '{1, 8, 64, 256, 1024};
  tmr8_core dut (.clk_sys_i, .rst_n_i, .clock_select_i, .waveform_select_i, .output_action_a_i,
    .output_action_b_i, .compare_a_value_i, .compare_b_value_i, .counter_write_i,
    .counter_write_data_i, .compare_a_flag_clear_i, .compare_b_flag_clear_i,
    .overflow_flag_clear_i, .counter_value_o, .counting_down_o, .wave_out_a_o, .wave_out_b_o,
    .compare_a_flag_o, .compare_b_flag_o, .overflow_flag_o);
  always #2.5 clk_sys_i = ~clk_sys_i;
  task automatic chk_v(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // full width: counts such as 258 or 1024 must not fold into a byte
  task automatic chk_n(input string nm, input int e, input int g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic cfg(input logic [2:0] ws, input logic [1:0] oa, input logic [7:0] ca);
    @(negedge clk_sys_i);
    rst_n_i = 1'b0;
    waveform_select_i = ws;
    output_action_a_i = oa;
    compare_a_value_i = ca;
    @(negedge clk_sys_i);
    rst_n_i = 1'b1;
  endtask
  // bounded, so a stuck counter shows as one failed compare, not a hang
  task automatic wait_cv(input logic [7:0] v);
    int k;
    k = 0;
    while (counter_value_o !== v && k < 3000) begin
      @(negedge clk_sys_i);
      k++;
    end
    chk_n("reach", 1, int'(k < 3000));
  endtask
  task automatic watch(input int n);
    logic a;
    logic b;
    hi = 0;
    tog_a = 0;
    tog_b = 0;
    top = 0;
    a = wave_out_a_o;
    b = wave_out_b_o;
    repeat (n) begin
      @(negedge clk_sys_i);
      if (wave_out_a_o === 1'b1) hi++;
      if (wave_out_a_o !== a) tog_a++;
      if (wave_out_b_o !== b) tog_b++;
      if (counter_value_o > top) top = counter_value_o;
      a = wave_out_a_o;
      b = wave_out_b_o;
    end
  endtask
  task automatic pulse_write(input logic [7:0] d);
    counter_write_i = 1'b1;
    counter_write_data_i = d;
    @(negedge clk_sys_i);
    counter_write_i = 1'b0;
    chk_v("write", d, counter_value_o);
  endtask
  task automatic t_ctc;
    cfg(3'h2, 2'h1, 8'h10);
    wait_cv(8'h10);
    watch(68);
    chk_n("ctc toggles", 4, tog_a);
    chk_n("ctc top", 8'h10, top);
    chk_v("cmp flag", 8'h01, compare_a_flag_o);
    chk_v("b flag", 8'h01, compare_b_flag_o);
    // clear away from any match: a set in the same cycle would win
    wait_cv(8'h03);
    compare_a_flag_clear_i = 1'b1;
    compare_b_flag_clear_i = 1'b1;
    @(negedge clk_sys_i);
    compare_a_flag_clear_i = 1'b0;
    compare_b_flag_clear_i = 1'b0;
    chk_v("flag clr", 8'h00, compare_a_flag_o);
    chk_v("b flag clr", 8'h00, compare_b_flag_o);
    pulse_write(8'h20);
    wait_cv(8'hFF);
    chk_v("no ovf", 8'h00, overflow_flag_o);
    chk_v("missed", 8'h00, compare_a_flag_o);
    @(negedge clk_sys_i);
    chk_v("wrap", 8'h00, counter_value_o);
    chk_v("ovf", 8'h01, overflow_flag_o);
    overflow_flag_clear_i = 1'b1;
    @(negedge clk_sys_i);
    overflow_flag_clear_i = 1'b0;
    chk_v("ovf clr", 8'h00, overflow_flag_o);
    $display("t_ctc done");
  endtask
  task automatic t_fast;
    cfg(3'h3, 2'h2, 8'h80);
    wait_cv(8'hFF);
    watch(512);
    chk_n("fast high", 258, hi);
    chk_n("fast toggles", 4, tog_a);
    chk_n("fast top", 8'hFF, top);
    wait_cv(8'h10);
    compare_a_value_i = 8'h20;
    wait_cv(8'h40);
    chk_v("buffered", 8'h01, wave_out_a_o);
    wait_cv(8'hFF);
    wait_cv(8'h40);
    chk_v("reloaded", 8'h00, wave_out_a_o);
    for (int i = 0; i < 2; i++) begin
      compare_a_value_i = i ? 8'hFF : 8'h00;
      wait_cv(8'h10);
      wait_cv(8'hFF);
      watch(256);
      chk_n("fast extreme", i ? 256 : 1, hi);
    end
    $display("t_fast done");
  endtask
  task automatic t_phase;
    cfg(3'h1, 2'h2, 8'h40);
    wait_cv(8'hFF);
    watch(1020);
    chk_n("phase high", 128 * 2, hi);
    chk_n("phase toggles", 4, tog_a);
    chk_n("phase top", 8'hFF, top);
    for (int i = 0; i < 2; i++) begin
      compare_a_value_i = i ? 8'hFF : 8'h00;
      wait_cv(8'h10);
      wait_cv(8'hFF);
      watch(510);
      chk_n("phase extreme", i ? 510 : 0, hi);
    end
    cfg(3'h1, 2'h3, 8'h10);
    pulse_write(8'h80);
    wait_cv(8'hFF);
    wait_cv(8'hF0);
    chk_v("sym start", 8'h01, wave_out_a_o);
    $display("t_phase done");
  endtask
  task automatic t_top;
    output_action_b_i = 2'h1;
    cfg(3'h7, 2'h1, 8'h03);
    wait_cv(8'h03);
    watch(64);
    chk_n("msb toggle", 16, tog_a);
    chk_n("b toggle", 0, tog_b);
    chk_n("fast cmp top", 3, top);
    cfg(3'h3, 2'h1, 8'h03);
    watch(512);
    chk_n("no msb toggle", 0, tog_a);
    cfg(3'h5, 2'h2, 8'h10);
    watch(64);
    chk_n("phase cmp top", 8'h10, top);
    $display("t_top done");
  endtask
  task automatic t_div;
    int n;
    for (int i = 0; i < 5; i++) begin
      clock_select_i = 3'(i + 1);
      cfg(3'h2, 2'h0, 8'hFF);
      wait_cv(8'h02);
      n = 0;
      while (counter_value_o === 8'h02 && n < 2000) begin
        @(negedge clk_sys_i);
        n++;
      end
      chk_n("tick gap", dv[i], n);
      chk_v("idle wave", 8'h00, wave_out_a_o);
    end
    clock_select_i = 3'h1;
    cfg(3'h0, 2'h0, 8'h00);
    wait_cv(8'hFF);
    @(negedge clk_sys_i);
    chk_v("normal wrap", 8'h00, counter_value_o);
    chk_v("normal ovf", 8'h01, overflow_flag_o);
    // the tick already registered still lands once after the stop
    clock_select_i = 3'h0;
    repeat (4) @(negedge clk_sys_i);
    chk_v("stopped", 8'h01, counter_value_o);
    $display("t_div done");
  endtask
  task automatic close_out;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #200us;
    errors++;
    close_out();
  end
  initial begin
    repeat (2) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    t_ctc();
    t_fast();
    t_phase();
    t_top();
    t_div();
    close_out();
  end
endmodule
